/* core/pio_fifo.sv */
// Synchronous FIFO with valid/ready on both sides.
`timescale 1ns/1ns
module pio_fifo #(
   parameter int unsigned WIDTH = 30,
   parameter int unsigned DEPTH = 32
) (
   input  wire logic  i_clock,
   input  wire logic  i_rst_n,
   pio_stream_if.snk  wr,
   pio_stream_if.src  rd
);
   localparam int unsigned AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wp_r;
   logic [AW:0]      wp_nxt;
   logic [AW:0]      rp_r;
   logic [AW:0]      rp_nxt;
   logic             full;
   logic             empty;
   logic             push;
   logic             pop;

   // The extra pointer bit tells a full buffer from an empty one.
   assign full     = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
   assign empty    = (wp_r == rp_r);
   assign wr.ready = !full;
   assign rd.valid = !empty;
   assign rd.data  = mem[rp_r[AW-1:0]];
   assign push     = wr.valid && !full;
   assign pop      = rd.ready && !empty;

   // Pointer advance.
   always_comb begin
      wp_nxt = wp_r + {{AW{1'b0}}, push};
      rp_nxt = rp_r + {{AW{1'b0}}, pop};
   end

   // Pointer registers.
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wp_r <= '0;
         rp_r <= '0;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
      end
   end

   // Storage needs no reset; an empty buffer never presents it.
   always_ff @(posedge i_clock) begin
      if (push) begin
         mem[wp_r[AW-1:0]] <= wr.data;
      end
   end
endmodule : pio_fifo

/* core/pio_host.sv */
// Peripheral-side controller for one input cable and one output cable of the channel.
//
// Summary of operation
// - Each transfer carries one thirty-bit word on thirty parallel data lines.
// - All lines are static levels held indefinitely; no timeout is ever assumed.
// - Requests go from peripheral to computer; acknowledges come back from the computer.
// - The third control line follows data: attention in, command strobe out.
// - The peripheral puts the word on the lines before raising the input request.
// - On input acknowledge the peripheral releases data lines and input request.
// - The input handshake repeats for every word of the input buffer.
// - Attention: place code, raise strobe, wait acknowledge, then drop both.
// - No attention strobe while an input word request is still unanswered.
// - The output request is raised only when a word can be accepted.
// - After output acknowledge the peripheral samples the data and may drop its request.
// - The output handshake repeats for every word of the output buffer.
// - Command: code then strobe from the computer; the peripheral detects and samples.
// - The peripheral sends no response to a command strobe.
// - A sender waits for receiver-block-open before placing its first word; the code waits before each word, and only when i_special is set.
`timescale 1ns/1ns
module pio_host
   import pio_pkg::*;
(
   input  wire logic              i_clock,
   input  wire logic              i_rst_n,
   // Input cable: words and attention codes travelling into the computer.
   output logic [WORD_W-1:0]      o_in_data,
   output logic                   o_in_req,
   output logic                   o_attn,
   input  wire logic              i_in_ack,
   input  wire logic              i_blk_open,
   // Output cable: words and command codes travelling out of the computer.
   input  wire logic [WORD_W-1:0] i_out_data,
   output logic                   o_out_req,
   input  wire logic              i_out_ack,
   input  wire logic              i_cmd_strobe,
   // User side: words to send.
   input  wire logic [WORD_W-1:0] i_tx_data,
   input  wire logic              i_tx_valid,
   output logic                   o_tx_ready,
   // User side: attention code to send.
   input  wire logic [WORD_W-1:0] i_attn_code,
   input  wire logic              i_attn_valid,
   output logic                   o_attn_ready,
   // User side: special-channel link, wait for block open before each word.
   input  wire logic              i_special,
   // User side: words received from the computer.
   input  wire logic              i_rx_enable,
   output logic [WORD_W-1:0]      o_rx_data,
   output logic                   o_rx_valid,
   input  wire logic              i_rx_ready,
   // User side: command codes received from the computer.
   output logic [WORD_W-1:0]      o_cmd_data,
   output logic                   o_cmd_valid
);

   // Synchronised control levels.
   logic [SYNC_W-1:0]    sync_in;
   logic [SYNC_W-1:0]    sync_q;
   logic                 in_ack_s;
   logic                 out_ack_s;
   logic                 cmd_s;
   logic                 blk_open_s;

   // Input-cable sequencer state.
   pio_in_state_t        in_state_r;
   pio_in_state_t        in_state_nxt;
   logic [WORD_W-1:0]    in_data_r;
   logic [WORD_W-1:0]    in_data_nxt;
   logic                 in_req_r;
   logic                 in_req_nxt;
   logic                 attn_r;
   logic                 attn_nxt;
   logic                 is_attn_r;
   logic                 is_attn_nxt;
   logic [GAP_CNT_W-1:0] in_gap_r;
   logic [GAP_CNT_W-1:0] in_gap_nxt;
   logic                 tx_pop;
   logic                 attn_take;

   // Output-cable sequencer state.
   pio_out_state_t       out_state_r;
   pio_out_state_t       out_state_nxt;
   logic                 out_req_r;
   logic                 out_req_nxt;
   logic [GAP_CNT_W-1:0] out_gap_r;
   logic [GAP_CNT_W-1:0] out_gap_nxt;
   logic [WORD_W-1:0]    rx_data_r;
   logic [WORD_W-1:0]    rx_data_nxt;
   logic                 rx_valid_r;
   logic                 rx_valid_nxt;

   // Command receiver state.
   logic                 cmd_prev_r;
   logic                 cmd_prev_nxt;
   logic [WORD_W-1:0]    cmd_data_r;
   logic [WORD_W-1:0]    cmd_data_nxt;
   logic                 cmd_valid_r;
   logic                 cmd_valid_nxt;

   // Buffer between the user and the input cable.
   pio_stream_if #(.WIDTH(WORD_W)) tx_wr ();
   pio_stream_if #(.WIDTH(WORD_W)) tx_rd ();

   // Every level from the computer is resynchronised before any decision.
   assign sync_in[SY_IN_ACK]   = i_in_ack;
   assign sync_in[SY_OUT_ACK]  = i_out_ack;
   assign sync_in[SY_CMD]      = i_cmd_strobe;
   assign sync_in[SY_BLK_OPEN] = i_blk_open;

   pio_sync #(
      .WIDTH   (SYNC_W)
   ) u_sync (
      .i_clock (i_clock),
      .i_rst_n (i_rst_n),
      .i_async (sync_in),
      .o_sync  (sync_q)
   );

   assign in_ack_s   = sync_q[SY_IN_ACK];
   assign out_ack_s  = sync_q[SY_OUT_ACK];
   assign cmd_s      = sync_q[SY_CMD];
   assign blk_open_s = sync_q[SY_BLK_OPEN];

   // The user fills the buffer; the input sequencer drains it one word per handshake.
   assign tx_wr.data  = i_tx_data;
   assign tx_wr.valid = i_tx_valid;
   assign o_tx_ready  = tx_wr.ready;
   assign tx_rd.ready = tx_pop;

   pio_fifo #(
      .WIDTH   (WORD_W),
      .DEPTH   (FIFO_DEPTH)
   ) u_tx_fifo (
      .i_clock (i_clock),
      .i_rst_n (i_rst_n),
      .wr      (tx_wr),
      .rd      (tx_rd)
   );

   // Input-cable sequencer: one word or attention code per acknowledge.
   // The computer decides when it samples, so the word waits with no timeout.
   always_comb begin
      in_state_nxt = in_state_r;
      in_data_nxt  = in_data_r;
      in_req_nxt   = in_req_r;
      attn_nxt     = attn_r;
      is_attn_nxt  = is_attn_r;
      in_gap_nxt   = in_gap_r;
      tx_pop       = 1'b0;
      attn_take    = 1'b0;
      case (in_state_r)
         IN_IDLE: begin
            // Only idle here, so an attention never overlaps an open word request.
            if (!in_ack_s) begin
               if (i_attn_valid) begin
                  in_data_nxt  = i_attn_code;
                  is_attn_nxt  = 1'b1;
                  attn_take    = 1'b1;
                  in_state_nxt = IN_SETUP;
               end else if (tx_rd.valid && (!i_special || blk_open_s)) begin
                  in_data_nxt  = tx_rd.data;
                  is_attn_nxt  = 1'b0;
                  tx_pop       = 1'b1;
                  in_state_nxt = IN_SETUP;
               end
            end
         end
         IN_SETUP: begin
            // Data has stood on the lines a full cycle before the strobe rises.
            if (is_attn_r) begin
               attn_nxt = 1'b1;
            end else begin
               in_req_nxt = 1'b1;
            end
            in_state_nxt = IN_HOLD;
         end
         IN_HOLD: begin
            // One shared acknowledge answers both kinds of strobe.
            if (in_ack_s) begin
               in_req_nxt   = 1'b0;
               attn_nxt     = 1'b0;
               in_data_nxt  = WORD_RST;
               in_state_nxt = IN_RELEASE;
            end
         end
         IN_RELEASE: begin
            // The acknowledge stays up for its fixed period; wait it out.
            if (!in_ack_s) begin
               in_gap_nxt   = GAP_LOAD;
               in_state_nxt = IN_GAP;
            end
         end
         IN_GAP: begin
            // Keep the request low long enough before the next word.
            if (in_gap_r == GAP_ZERO) begin
               in_state_nxt = IN_IDLE;
            end else begin
               in_gap_nxt = in_gap_r - 8'h01;
            end
         end
         default: begin
            in_state_nxt = IN_IDLE;
            in_req_nxt   = 1'b0;
            attn_nxt     = 1'b0;
         end
      endcase
   end

   // Input-cable registers.
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         in_state_r <= IN_IDLE;
         in_data_r  <= WORD_RST;
         in_req_r   <= 1'b0;
         attn_r     <= 1'b0;
         is_attn_r  <= 1'b0;
         in_gap_r   <= GAP_ZERO;
      end else begin
         in_state_r <= in_state_nxt;
         in_data_r  <= in_data_nxt;
         in_req_r   <= in_req_nxt;
         attn_r     <= attn_nxt;
         is_attn_r  <= is_attn_nxt;
         in_gap_r   <= in_gap_nxt;
      end
   end

   assign o_in_data    = in_data_r;
   assign o_in_req     = in_req_r;
   assign o_attn       = attn_r;
   assign o_attn_ready = attn_take;

   // Output-cable sequencer: ask for a word only when the holding register is free.
   // The computer places data, waits, then acknowledges; sampling on the synchronised
   // acknowledge therefore sees settled lines.
   always_comb begin
      out_state_nxt = out_state_r;
      out_req_nxt   = out_req_r;
      out_gap_nxt   = out_gap_r;
      rx_data_nxt   = rx_data_r;
      rx_valid_nxt  = rx_valid_r;
      // Consumption first, so a capture in the same cycle wins.
      if (rx_valid_r && i_rx_ready) begin
         rx_valid_nxt = 1'b0;
      end
      case (out_state_r)
         OUT_IDLE: begin
            if (i_rx_enable && !rx_valid_r && !out_ack_s) begin
               out_req_nxt   = 1'b1;
               out_state_nxt = OUT_REQ;
            end
         end
         OUT_REQ: begin
            if (out_ack_s) begin
               rx_data_nxt   = i_out_data;
               rx_valid_nxt  = 1'b1;
               out_req_nxt   = 1'b0;
               out_state_nxt = OUT_WAIT_LOW;
            end
         end
         OUT_WAIT_LOW: begin
            // The computer closes the word by dropping its acknowledge.
            if (!out_ack_s) begin
               out_gap_nxt   = GAP_LOAD;
               out_state_nxt = OUT_GAP;
            end
         end
         OUT_GAP: begin
            // A request low for too short a time would be ignored by the computer.
            if (out_gap_r == GAP_ZERO) begin
               out_state_nxt = OUT_IDLE;
            end else begin
               out_gap_nxt = out_gap_r - 8'h01;
            end
         end
         default: begin
            out_state_nxt = OUT_IDLE;
            out_req_nxt   = 1'b0;
         end
      endcase
   end

   // Output-cable registers.
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         out_state_r <= OUT_IDLE;
         out_req_r   <= 1'b0;
         out_gap_r   <= GAP_ZERO;
         rx_data_r   <= WORD_RST;
         rx_valid_r  <= 1'b0;
      end else begin
         out_state_r <= out_state_nxt;
         out_req_r   <= out_req_nxt;
         out_gap_r   <= out_gap_nxt;
         rx_data_r   <= rx_data_nxt;
         rx_valid_r  <= rx_valid_nxt;
      end
   end

   assign o_out_req  = out_req_r;
   assign o_rx_data  = rx_data_r;
   assign o_rx_valid = rx_valid_r;

   // Command receiver: the code shares the output data lines and is told apart
   // only by its strobe. Nothing is sent back; the computer times it alone.
   always_comb begin
      cmd_prev_nxt  = cmd_s;
      cmd_valid_nxt = cmd_s && !cmd_prev_r;
      cmd_data_nxt  = cmd_data_r;
      if (cmd_s && !cmd_prev_r) begin
         cmd_data_nxt = i_out_data;
      end
   end

   // Command registers.
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cmd_prev_r  <= 1'b0;
         cmd_data_r  <= WORD_RST;
         cmd_valid_r <= 1'b0;
      end else begin
         cmd_prev_r  <= cmd_prev_nxt;
         cmd_data_r  <= cmd_data_nxt;
         cmd_valid_r <= cmd_valid_nxt;
      end
   end

   // The command pulse has no ready: a code missed by the user is simply overwritten.
   assign o_cmd_data  = cmd_data_r;
   assign o_cmd_valid = cmd_valid_r;

endmodule : pio_host

/* core/pio_sync.sv */
// Bank of two-stage synchronisers for the asynchronous control levels.
`timescale 1ns/1ns
module pio_sync #(
   parameter int unsigned WIDTH = 4
) (
   input  wire logic             i_clock,
   input  wire logic             i_rst_n,
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);
   genvar b;

   // The first stage feeds only the second, so nothing sees a metastable level.
   generate
      for (b = 0; b < WIDTH; b++) begin : g_bit
         logic meta_r;
         logic sync_r;
         always_ff @(posedge i_clock or negedge i_rst_n) begin
            if (!i_rst_n) begin
               meta_r <= 1'b0;
               sync_r <= 1'b0;
            end else begin
               meta_r <= i_async[b];
               sync_r <= meta_r;
            end
         end
         assign o_sync[b] = sync_r;
      end
   endgenerate
endmodule : pio_sync

/* dv/pio_cpu_model.sv */
// Behavioural model of the computer behind both cables.
`timescale 1ns/1ns
module pio_cpu_model
   import pio_pkg::*;
#(
   parameter int ACK_HOLD  = 296,
   parameter int SETUP     = 88,
   parameter int DATA_HOLD = 84,
   parameter int ACK_LOW   = 184
) (
   input  wire logic              i_clock,
   input  wire logic              i_rst_n,
   input  wire logic [WORD_W-1:0] i_in_data,
   input  wire logic              i_in_req,
   input  wire logic              i_attn,
   output logic                   o_in_ack,
   input  wire logic              i_out_req,
   output logic      [WORD_W-1:0] o_out_data,
   output logic                   o_out_ack,
   output logic                   o_cmd_strobe,
   input  wire logic              i_blk_en,
   output logic                   o_blk_open,
   input  wire logic              i_slow,
   input  wire logic [WORD_W-1:0] i_word,
   input  wire logic              i_cmd_go,
   input  wire logic [WORD_W-1:0] i_cmd_code,
   output logic      [WORD_W-1:0] o_seen_data,
   output logic                   o_seen_attn,
   output logic      [7:0]        o_seen_cnt
);
   // Lines change just after a rising edge.
   task automatic step(input int n);
      repeat (n) @(posedge i_clock);
      #2;
   endtask : step

   // Block-open stands as long as the bench asks.
   assign o_blk_open = i_blk_en;

   // Input cable: sample at leisure, then acknowledge for a fixed time.
   initial begin
      {o_in_ack, o_seen_data, o_seen_attn, o_seen_cnt} = '0;
      wait (i_rst_n === 1'h1);
      forever begin
         step(1);
         if (i_in_req === 1'h1 || i_attn === 1'h1) begin
            step(i_slow ? 40 : 3);
            o_seen_data = i_in_data;
            o_seen_attn = i_attn;
            o_seen_cnt  = o_seen_cnt + 8'h01;
            o_in_ack    = 1'h1;
            step(ACK_HOLD);
            o_in_ack = 1'h0;
            step(ACK_LOW);
         end
      end
   end

   // Words and commands share the data lines, so one process owns them.
   initial begin
      bit cmd;
      o_out_data = '1;
      {o_out_ack, o_cmd_strobe} = '0;
      wait (i_rst_n === 1'h1);
      forever begin
         step(1);
         cmd = (i_cmd_go === 1'h1);
         if (cmd || i_out_req === 1'h1) begin
            if (!cmd) step(i_slow ? 40 : 2);
            o_out_data = cmd ? i_cmd_code : i_word;
            step(SETUP);
            {o_cmd_strobe, o_out_ack} = {cmd, !cmd};
            step(ACK_HOLD);
            {o_cmd_strobe, o_out_ack} = '0;
            step(DATA_HOLD);
            // Released lines show the inverse, so a stale word cannot pass.
            o_out_data = ~o_out_data;
            step(ACK_LOW);
         end
      end
   end
endmodule : pio_cpu_model

/* dv/pio_host_assertions.sv */
// Port-level checks of the peripheral-side channel controller.
`timescale 1ns/1ns
module pio_host_assertions
   import pio_pkg::*;
(
   input wire logic              i_clock,
   input wire logic              i_rst_n,
   input wire logic [WORD_W-1:0] o_in_data,
   input wire logic              o_in_req,
   input wire logic              o_attn,
   input wire logic              i_in_ack,
   input wire logic [WORD_W-1:0] i_out_data,
   input wire logic              o_out_req,
   input wire logic              i_cmd_strobe,
   input wire logic [WORD_W-1:0] i_attn_code,
   input wire logic              o_attn_ready,
   input wire logic              i_rx_enable,
   input wire logic [WORD_W-1:0] o_rx_data,
   input wire logic              o_rx_valid,
   input wire logic              i_rx_ready,
   input wire logic [WORD_W-1:0] o_cmd_data,
   input wire logic              o_cmd_valid
);
   logic       in_busy;
   logic [7:0] in_low_r;
   logic [7:0] in_low_nxt;
   logic [7:0] out_low_r;
   logic [7:0] out_low_nxt;

   // Either request line of the input cable is up.
   assign in_busy = o_in_req | o_attn;

   // Low-time counters saturate, so a long idle never wraps into a short gap.
   always_comb begin
      in_low_nxt  = in_busy ? 8'h00 : in_low_r + {7'h00, in_low_r != 8'hff};
      out_low_nxt = o_out_req ? 8'h00 : out_low_r + {7'h00, out_low_r != 8'hff};
   end

   // Counters start full: the first request has no earlier word.
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         in_low_r  <= 8'hff;
         out_low_r <= 8'hff;
      end else begin
         in_low_r  <= in_low_nxt;
         out_low_r <= out_low_nxt;
      end
   end

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);

   sequence attn_load_s;
      (o_in_data == $past(i_attn_code)) ##1 o_attn;
   endsequence

   sequence cmd_pulse_s;
      (o_cmd_data == $past(i_out_data)) ##1 !o_cmd_valid;
   endsequence

   in_setup_a: assert property ($rose(o_in_req) |-> $stable(o_in_data))
      else $error("word changed at request rise");
   in_hold_a: assert property (in_busy && $past(in_busy) |-> $stable(o_in_data))
      else $error("word changed under request");
   attn_excl_a: assert property (!(o_attn && o_in_req))
      else $error("attention raised beside a word request");
   in_release_a: assert property ($rose(i_in_ack) |-> ##[1:4] !in_busy)
      else $error("request held after acknowledge");
   in_zero_a: assert property ($fell(in_busy) |-> ##[0:1] (o_in_data == WORD_RST))
      else $error("input data lines not released");
   in_gap_a: assert property ($rose(in_busy) |-> in_low_r >= REQ_GAP_CYC)
      else $error("input gap too short");
   attn_load_a: assert property (o_attn_ready |=> attn_load_s)
      else $error("attention code not placed first");
   out_able_a: assert property ($rose(o_out_req) |-> $past(i_rx_enable) && !$past(o_rx_valid))
      else $error("output request raised with no room");
   out_gap_a: assert property ($rose(o_out_req) |-> out_low_r >= REQ_GAP_CYC)
      else $error("output gap too short");
   rx_capture_a: assert property ($rose(o_rx_valid) |-> (o_rx_data == $past(i_out_data)) && !o_out_req)
      else $error("output word captured wrongly");
   rx_hold_a: assert property (o_rx_valid && !i_rx_ready |=> o_rx_valid && $stable(o_rx_data))
      else $error("received word lost");
   cmd_detect_a: assert property ($rose(i_cmd_strobe) |-> ##[1:4] o_cmd_valid)
      else $error("command strobe not detected");
   cmd_pulse_a: assert property (o_cmd_valid |-> cmd_pulse_s)
      else $error("command code or pulse wrong");
endmodule : pio_host_assertions

bind pio_host pio_host_assertions pio_host_assertions_i (
   .i_clock, .i_rst_n, .o_in_data, .o_in_req, .o_attn, .i_in_ack, .i_out_data, .o_out_req,
   .i_cmd_strobe, .i_attn_code, .o_attn_ready, .i_rx_enable, .o_rx_data, .o_rx_valid,
   .i_rx_ready, .o_cmd_data, .o_cmd_valid
);

/* dv/tb_top.sv */
// Self-checking bench of the channel controller.
`timescale 1ns/1ns
module tb_top import pio_pkg::*;;
   localparam logic [29:0] TX_BASE = 30'h2a5_0000;
   logic              i_clock, i_rst_n, o_in_req, o_attn, i_in_ack, i_blk_open, o_out_req;
   logic              i_out_ack, i_cmd_strobe, i_tx_valid, o_tx_ready, i_attn_valid, o_attn_ready;
   logic              i_special, i_rx_enable, o_rx_valid, i_rx_ready, o_cmd_valid;
   logic [WORD_W-1:0] o_in_data, i_out_data, i_tx_data, i_attn_code, o_rx_data, o_cmd_data;
   logic              blk_en, slow, cmd_go, seen_attn;
   logic [WORD_W-1:0] word, cmd_code, seen_data;
   logic [7:0]        seen_cnt;
   int                error_cnt, check_count;

   pio_host pio_host_i (.i_clock, .i_rst_n, .o_in_data, .o_in_req, .o_attn, .i_in_ack, .i_blk_open,
      .i_out_data, .o_out_req, .i_out_ack, .i_cmd_strobe, .i_tx_data, .i_tx_valid, .o_tx_ready,
      .i_attn_code, .i_attn_valid, .o_attn_ready, .i_special, .i_rx_enable, .o_rx_data,
      .o_rx_valid, .i_rx_ready, .o_cmd_data, .o_cmd_valid);

   pio_cpu_model pio_cpu_model_i (.i_clock, .i_rst_n, .i_in_data(o_in_data), .i_in_req(o_in_req),
      .i_attn(o_attn), .o_in_ack(i_in_ack), .i_out_req(o_out_req), .o_out_data(i_out_data),
      .o_out_ack(i_out_ack), .o_cmd_strobe(i_cmd_strobe), .i_blk_en(blk_en), .o_blk_open(i_blk_open),
      .i_slow(slow), .i_word(word), .i_cmd_go(cmd_go), .i_cmd_code(cmd_code),
      .o_seen_data(seen_data), .o_seen_attn(seen_attn), .o_seen_cnt(seen_cnt));

   // Free-running 20 MHz clock.
   initial begin
      i_clock = 1'h0;
      forever #25 i_clock = ~i_clock;
   end

   task automatic step(input int n);
      repeat (n) @(posedge i_clock);
      #2;
   endtask : step

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         error_cnt++;
      end
   endtask : chk

   // Bounded waits; a timeout shows up as a failed compare.
   task automatic wait_high(ref logic s, input int n);
      for (int i = 0; i < n && s !== 1'h1; i++) step(1);
      chk(s, 32'h1);
   endtask : wait_high

   task automatic wait_seen(input logic [7:0] prev);
      for (int i = 0; i < 1500 && seen_cnt === prev; i++) step(1);
      chk(seen_cnt, prev + 8'h01);
   endtask : wait_seen

   task automatic finish_test();
      if (error_cnt == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : finish_test

   task automatic t_reset();
      chk({o_in_req, o_attn, o_out_req, o_rx_valid, o_cmd_valid, o_tx_ready, o_attn_ready}, 32'h2);
      chk(o_in_data, WORD_RST);
   endtask : t_reset

   // Fill the buffer with the block shut, then drain it in order.
   task automatic t_fill_drain();
      int         n = 0;
      logic [7:0] c;
      i_special = 1'h1;
      while (o_tx_ready === 1'h1 && n < 40) begin
         i_tx_data  = TX_BASE + 30'(n);
         i_tx_valid = 1'h1;
         step(1);
         n++;
      end
      i_tx_valid = 1'h0;
      chk(n, FIFO_DEPTH);
      step(20);
      chk(o_in_req, 32'h0);
      {slow, blk_en} = 2'h3;
      for (n = 0; n < FIFO_DEPTH; n++) begin
         c = seen_cnt;
         if (n == 4) slow = 1'h0;
         wait_seen(c);
         chk(seen_data, TX_BASE + 30'(n));
         chk(seen_attn, 32'h0);
      end
      {blk_en, i_special} = '0;
   endtask : t_fill_drain

   // An attention offered during a word request waits for its answer.
   task automatic t_attn();
      logic [7:0] c;
      c          = seen_cnt;
      i_tx_data  = 30'h0ab_cdef;
      i_tx_valid = 1'h1;
      step(1);
      i_tx_valid = 1'h0;
      while (o_in_req === 1'h1) step(1);
      wait_high(o_in_req, 600);
      i_attn_code  = 30'h3c0_ffee;
      i_attn_valid = 1'h1;
      wait_seen(c);
      chk(seen_data, 30'h0ab_cdef);
      chk(seen_attn, 32'h0);
      c = seen_cnt;
      wait_high(o_attn_ready, 1000);
      step(1);
      i_attn_valid = 1'h0;
      wait_seen(c);
      chk(seen_data, 30'h3c0_ffee);
      chk(seen_attn, 32'h1);
   endtask : t_attn

   // One output word per request; the user stalls before taking each.
   task automatic t_output();
      for (int k = 0; k < 3; k++) begin
         word        = 30'h1f0_0000 + 30'(k * 5);
         i_rx_enable = 1'h1;
         wait_high(o_rx_valid, 1500);
         chk(o_rx_data, word);
         step(5);
         chk({o_rx_valid, o_out_req}, 32'h2);
         i_rx_ready = 1'h1;
         step(1);
         i_rx_ready = 1'h0;
         chk(o_rx_valid, 32'h0);
      end
      i_rx_enable = 1'h0;
   endtask : t_output

   // Commands come on the output data lines under their own strobe, with no reply.
   task automatic t_cmd();
      for (int k = 0; k < 2; k++) begin
         cmd_code = k ? 30'h155_5555 : 30'h2aa_aaaa;
         cmd_go   = 1'h1;
         wait_high(o_cmd_valid, 1000);
         chk(o_cmd_data, cmd_code);
         cmd_go = 1'h0;
         step(1);
         chk({o_cmd_valid, o_out_req}, 32'h0);
      end
   endtask : t_cmd

   // Reset for eight cycles, then each scenario in turn.
   initial begin
      {i_rst_n, i_tx_data, i_tx_valid, i_attn_code, i_attn_valid, i_special, i_rx_enable} = '0;
      {i_rx_ready, blk_en, slow, word, cmd_go, cmd_code} = '0;
      step(8);
      t_reset();
      i_rst_n = 1'h1;
      step(2);
      t_fill_drain();
      t_attn();
      t_output();
      t_cmd();
      finish_test();
   end

   // A run takes about 20000 cycles; a hang is cut short here.
   initial begin
      repeat (60000) @(posedge i_clock);
      error_cnt++;
      finish_test();
   end
endmodule : tb_top

/* inc/pio_pkg.sv */
// Constants and state types shared by the peripheral-side channel controller.
package pio_pkg;

   // Word and buffer geometry.
   localparam int unsigned WORD_W        = 30;
   localparam int unsigned FIFO_DEPTH    = 32;
   localparam logic [29:0] WORD_RST      = 30'h0000_0000;

   // Clock rate and the least low time of a request line between two words.
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned REQ_GAP_NS    = 10000;
   // A least time rounds up to whole cycles.
   localparam int unsigned REQ_GAP_CYC   = (REQ_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned GAP_CNT_W     = 8;
   localparam logic [7:0]  GAP_LOAD      = 8'(REQ_GAP_CYC - 1);
   localparam logic [7:0]  GAP_ZERO      = 8'h00;

   // Positions of the control inputs in the synchroniser bank.
   localparam int unsigned SYNC_W        = 4;
   localparam int unsigned SY_IN_ACK     = 0;
   localparam int unsigned SY_OUT_ACK    = 1;
   localparam int unsigned SY_CMD        = 2;
   localparam int unsigned SY_BLK_OPEN   = 3;

   // Sequencer that offers words and attention codes to the computer.
   typedef enum logic [2:0] {
      IN_IDLE,
      IN_SETUP,
      IN_HOLD,
      IN_RELEASE,
      IN_GAP
   } pio_in_state_t;

   // Sequencer that asks the computer for output words.
   typedef enum logic [1:0] {
      OUT_IDLE,
      OUT_REQ,
      OUT_WAIT_LOW,
      OUT_GAP
   } pio_out_state_t;

endpackage : pio_pkg

/* inc/pio_stream_if.sv */
// Valid/ready word stream carried between the controller and its buffer.
`timescale 1ns/1ns
interface pio_stream_if #(
   parameter int unsigned WIDTH = 30
);
   logic [WIDTH-1:0] data;
   logic             valid;
   logic             ready;

   // The producing end drives data and valid, the consuming end ready.
   modport src (output data, output valid, input  ready);
   modport snk (input  data, input  valid, output ready);
endinterface : pio_stream_if
